// ==== verilog/downlink_framer.sv ====
// Telemetry downlink word framer and list sequencer.
// Assumes an end pulse pin from the telemetry programmer and a one-cycle source read port.
// How it works
// - Each end pulse loads the next two registers into output channels 34 and 35.
// - A downlink word is 40 bits: 33 significant plus seven repetition bits.
// - Order bit, then first register, then second; each 15 data bits plus parity.
// - Seven filler bits repeat the first seven bits of the first register.
// - Word one carries identifier then sync, order bit zero.
// - Other words carry order bit one, except nominal word 51 which carries zero.
// - Every list identifier is negative.
// - Nominal word 51 carries elapsed time high and low, first register positive.
// - Seven list types, six with a fixed negative identifier plus the dump list set by DUMP_ID, descent list 77773 octal.
// - The sync register always holds 111 111 011 100 000 0.
// - A nominal list is 100 words, 200 registers, sent at 50 words per second.
// - The request register is read only at a pass start; no mid-pass switch.
// - An active dump list runs all its passes, ignoring other requests.
// - On nominal lists word 2 captures the 24 registers of words 2-13; 3-13 come from the buffer.
// - Word 52 captures words 52-63 likewise; 53-63 are served from the buffer.
// - Other words read live sources at transmit time.
// - On nominal lists words 45-50 carry display table registers; 91-94 carry channel images.
`include "downlink_map.svh"

module downlink_framer #(
  parameter logic [14:0] DUMP_ID     = 15'h7ff9, // Dump list identifier
  parameter logic [7:0]  DUMP_PASSES = 8'h02     // Passes of one dump
) (
  input  wire logic                   I_CLK,          // System clock, 125 MHz
  input  wire logic                   I_RST_B,        // Synchronous reset, active low
  input  wire logic                   I_END_PULSE,    // End pulse pin from telemetry
  input  wire logic [14:0]            I_LIST_REQ,     // Requested list identifier
  input  wire logic [14:0]            I_ELAPSED_HIGH, // Elapsed time high half
  input  wire logic [14:0]            I_ELAPSED_LOW,  // Elapsed time low half
  input  wire logic [14:0]            I_SRC_DATA,     // Source data, cycle after read
  output      logic                   O_SRC_RD,       // Source read strobe
  output      downlink_pkg::src_sel_t O_SRC_SEL,      // Source class
  output      logic [7:0]             O_SRC_IDX,      // Source register index
  output      logic [15:0]            O_CH34,         // First register with parity
  output      logic [15:0]            O_CH35,         // Second register with parity
  output      logic [39:0]            O_WORD,         // Framed word, MSB sent first
  output      logic                   O_WORD_VALID,   // New word loaded
  output      logic [6:0]             O_WORD_NUM,     // Word number in list
  output      downlink_pkg::list_t    O_LIST          // List of the current pass
);
  import downlink_pkg::*;

  localparam frm_state_t RST = '{st: ST_IDLE, word: `LIST_WORDS, list: LIST_COAST,
                                 src_sel: SRC_REGULAR, default: '0};

  frm_state_t q;
  frm_state_t d;
  logic       ep_rise;
  logic       nominal;
  logic       fixed_w;
  logic       capture;
  logic       buffered;
  logic       bank;
  logic [4:0] n_regs;
  logic [6:0] first_w;
  logic [14:0] rdat;

  snap_if #(.AW(6), .DW(15)) snap ();

  snapshot_mem #(.AW(6), .DW(15), .DEPTH(48)) u_mem (
    .i_clk (I_CLK),
    .bus   (snap)
  );

  // Register with odd parity appended after the data bits
  function automatic logic [15:0] par16(input logic [14:0] v);
    return {v, ~^v};
  endfunction

  function automatic logic [14:0] id_of(input list_t l);
    unique case (l)
      LIST_ORBIT:   return `ID_ORBIT;
      LIST_COAST:   return `ID_COAST;
      LIST_RNDZ:    return `ID_RNDZ;
      LIST_DESCENT: return `ID_DESCENT;
      LIST_SURFACE: return `ID_SURFACE;
      LIST_INIT:    return `ID_INIT;
      default:      return DUMP_ID;
    endcase
  endfunction

  // Unknown identifiers leave the current list running
  function automatic list_t list_of(input logic [14:0] id, input list_t cur);
    list_t r;
    r = cur;
    if (id == `ID_ORBIT)   r = LIST_ORBIT;
    if (id == `ID_COAST)   r = LIST_COAST;
    if (id == `ID_RNDZ)    r = LIST_RNDZ;
    if (id == `ID_DESCENT) r = LIST_DESCENT;
    if (id == `ID_SURFACE) r = LIST_SURFACE;
    if (id == `ID_INIT)    r = LIST_INIT;
    return r;
  endfunction

  function automatic logic [7:0] chan_of(input logic [2:0] k);
    unique case (k)
      3'h0: return `CHAN_A0;
      3'h1: return `CHAN_A1;
      3'h2: return `CHAN_B0;
      3'h3: return `CHAN_B1;
      3'h4: return `CHAN_C0;
      3'h5: return `CHAN_C1;
      3'h6: return `CHAN_D0;
      3'h7: return `CHAN_D1;
    endcase
  endfunction

  // Word classification; snapshots exist only on nominal lists
  assign ep_rise  = q.ep[1] & ~q.ep[2];
  assign nominal  = (q.list != LIST_DUMP);
  assign fixed_w  = (q.word == 7'h01) || (nominal && q.word == `MID_WORD);
  assign capture  = nominal && (q.word == `SNAP_A_FIRST || q.word == `SNAP_B_FIRST);
  assign buffered = nominal && ((q.word > `SNAP_A_FIRST && q.word <= `SNAP_A_LAST) ||
                                (q.word > `SNAP_B_FIRST && q.word <= `SNAP_B_LAST));
  assign bank     = (q.word >= `SNAP_B_FIRST);
  assign first_w  = bank ? `SNAP_B_FIRST : `SNAP_A_FIRST;
  assign n_regs   = capture ? `SNAP_REGS : 5'h02;
  assign rdat     = buffered ? snap.rdata : I_SRC_DATA;

  // Snapshot port; capture writes each returned source register
  assign snap.we    = q.pend && capture;
  assign snap.waddr = (bank ? 6'h18 : 6'h00) + {1'b0, q.pidx};
  assign snap.wdata = I_SRC_DATA;
  assign snap.re    = q.mrd;
  assign snap.raddr = q.maddr;

  // Next state of the whole framer
  always_comb begin
    d        = q;
    d.ep     = {q.ep[1:0], I_END_PULSE}; // ep[0] only feeds ep[1]
    d.wvalid = 1'b0;
    d.src_rd = 1'b0;
    d.mrd    = 1'b0;
    d.pend   = q.src_rd | q.mrd;
    d.pidx   = q.ridx;
    unique case (q.st)
      ST_IDLE: begin
        // Pulses while a word is being built are dropped; a word takes under 30 cycles
        if (ep_rise) begin
          d.st  = ST_FETCH;
          d.cnt = 5'h00;
          if (q.word == `LIST_WORDS) begin
            d.word = 7'h01;
            // List chosen only here, never inside a pass
            if (q.list == LIST_DUMP && q.dump_left != 8'h00) begin
              d.dump_left = q.dump_left - 8'h01;
            end else if (I_LIST_REQ == DUMP_ID) begin
              d.list      = LIST_DUMP;
              d.dump_left = DUMP_PASSES - 8'h01;
            end else begin
              d.list = list_of(I_LIST_REQ, q.list);
            end
          end else begin
            d.word = q.word + 7'h01;
          end
        end
      end
      ST_FETCH: begin
        if (fixed_w) begin
          // Identifier and sync, or elapsed time with sign forced clear
          d.r1 = (q.word == 7'h01) ? id_of(q.list) : {1'b0, I_ELAPSED_HIGH[13:0]};
          d.r2 = (q.word == 7'h01) ? `SYNC_BITS : I_ELAPSED_LOW;
          d.st = ST_LOAD;
        end else begin
          if (q.cnt < n_regs) begin
            d.cnt  = q.cnt + 5'h01;
            d.ridx = q.cnt;
            if (buffered) begin
              d.mrd   = 1'b1;
              d.maddr = (bank ? 6'h18 : 6'h00) + 6'({q.word - first_w, 1'b0}) + {1'b0, q.cnt};
            end else begin
              d.src_rd  = 1'b1;
              d.src_sel = SRC_REGULAR;
              d.src_idx = {q.word - 7'h01, 1'b0} + {3'h0, q.cnt};
              if (nominal && q.word >= `DISP_FIRST && q.word <= `DISP_LAST) begin
                d.src_sel = SRC_DISPLAY;
                d.src_idx = {q.word - `DISP_FIRST, 1'b0} + {3'h0, q.cnt};
              end
              if (nominal && q.word >= `CHAN_FIRST && q.word <= `CHAN_LAST) begin
                d.src_sel = SRC_CHANNEL;
                d.src_idx = chan_of(3'({q.word - `CHAN_FIRST, 1'b0}) + 3'(q.cnt));
              end
            end
          end
          // Returned data: first pair forms this word's registers
          if (q.pend) begin
            if (q.pidx == 5'h00) d.r1 = rdat;
            if (q.pidx == 5'h01) d.r2 = rdat;
            if (q.pidx == n_regs - 5'h01) d.st = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        d.ch34   = par16(q.r1);
        d.ch35   = par16(q.r2);
        // Order bit, two registers, then filler from the first register
        // Filler is the top seven data bits, i.e. the first seven bits of the first register
        d.wrd    = {~fixed_w, par16(q.r1), par16(q.r2), q.r1[14:8]};
        d.wvalid = 1'b1;
        d.st     = ST_IDLE;
      end
    endcase
  end

  // Single state register
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign O_SRC_RD     = q.src_rd;
  assign O_SRC_SEL    = q.src_sel;
  assign O_SRC_IDX    = q.src_idx;
  assign O_CH34       = q.ch34;
  assign O_CH35       = q.ch35;
  assign O_WORD       = q.wrd;
  assign O_WORD_VALID = q.wvalid;
  assign O_WORD_NUM   = q.word;
  assign O_LIST       = q.list;

  // Checks
  sequence s_start;
    q.st == ST_IDLE && ep_rise;
  endsequence
  sequence s_out;
    q.wvalid;
  endsequence

  property p_load;
    @(posedge I_CLK) disable iff (!I_RST_B) s_start |-> ##[2:30] s_out;
  endproperty
  a_load: assert property (p_load) else $error("no word after end pulse");

  property p_frame;
    @(posedge I_CLK) disable iff (!I_RST_B)
      s_out |-> O_WORD[38:23] == O_CH34 && O_WORD[22:7] == O_CH35 && O_WORD[6:0] == O_CH34[15:9];
  endproperty
  a_frame: assert property (p_frame) else $error("word layout wrong");

  property p_parity;
    @(posedge I_CLK) disable iff (!I_RST_B) s_out |-> (^O_CH34) && (^O_CH35);
  endproperty
  a_parity: assert property (p_parity) else $error("even parity register");

  property p_first;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (s_out and (q.word == 7'h01)) |-> !O_WORD[39] && O_CH34[15] && O_CH35 == par16(`SYNC_BITS);
  endproperty
  a_first: assert property (p_first) else $error("bad first word");

  property p_order;
    @(posedge I_CLK) disable iff (!I_RST_B)
      s_out |-> O_WORD[39] == !(q.word == 7'h01 || (nominal && q.word == `MID_WORD));
  endproperty
  a_order: assert property (p_order) else $error("order bit wrong");

  property p_mid;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (s_out and (nominal && q.word == `MID_WORD)) |->
        !O_CH34[15] && O_CH35[15:1] == $past(I_ELAPSED_LOW, 2);
  endproperty
  a_mid: assert property (p_mid) else $error("mid word wrong");

  property p_switch;
    @(posedge I_CLK) disable iff (!I_RST_B) !$stable(q.list) |-> q.word == 7'h01 && $past(q.word) == `LIST_WORDS;
  endproperty
  a_switch: assert property (p_switch) else $error("list changed mid pass");

  property p_dump;
    @(posedge I_CLK) disable iff (!I_RST_B)
      (s_start and (q.list == LIST_DUMP && q.dump_left != 8'h00)) |=> q.list == LIST_DUMP;
  endproperty
  a_dump: assert property (p_dump) else $error("dump list left early");

  property p_buf;
    @(posedge I_CLK) disable iff (!I_RST_B) q.st == ST_FETCH && buffered |-> !d.src_rd;
  endproperty
  a_buf: assert property (p_buf) else $error("snapshot word read live");

  property p_cap;
    @(posedge I_CLK) disable iff (!I_RST_B)
      // Strobe in the first 8 read cycles and the 24th, strobe drops, then the word two cycles later
      q.st == ST_FETCH && capture && q.cnt == 5'h00 && !q.pend |->
        ##1 O_SRC_RD [*8] ##16 O_SRC_RD ##1 !O_SRC_RD ##2 s_out;
  endproperty
  a_cap: assert property (p_cap) else $error("capture did not read sources");

  property p_disp;
    @(posedge I_CLK) disable iff (!I_RST_B)
      O_SRC_RD && nominal && q.word >= `DISP_FIRST && q.word <= `DISP_LAST |-> O_SRC_SEL == SRC_DISPLAY;
  endproperty
  a_disp: assert property (p_disp) else $error("display words from wrong source");
endmodule // downlink_framer

// ==== verilog/downlink_map.svh ====
// Numeric constants of the downlink word framer: list layout, identifiers, sync.
// Assumes inclusion by bare name from files that also import downlink_pkg.
`ifndef DOWNLINK_MAP_SVH
`define DOWNLINK_MAP_SVH

// List layout, in word numbers counted from one
`define LIST_WORDS     7'h64
`define MID_WORD       7'h33
`define SNAP_A_FIRST   7'h02
`define SNAP_A_LAST    7'h0d
`define SNAP_B_FIRST   7'h34
`define SNAP_B_LAST    7'h3f
`define DISP_FIRST     7'h2d
`define DISP_LAST      7'h32
`define CHAN_FIRST     7'h5b
`define CHAN_LAST      7'h5e
`define SNAP_REGS      5'h18

// Fifteen data bits of the fixed registers, parity added on framing
`define ID_ORBIT       15'h7ffc
`define ID_COAST       15'h7fff
`define ID_RNDZ        15'h7ffd
`define ID_DESCENT     15'h7ffb
`define ID_SURFACE     15'h7ffa
`define ID_INIT        15'h7ffe
`define SYNC_BITS      15'h7ee0

// Input/output channel numbers carried by words 91 to 94
`define CHAN_A0        8'h0b
`define CHAN_A1        8'h0c
`define CHAN_B0        8'h0d
`define CHAN_B1        8'h0e
`define CHAN_C0        8'h1e
`define CHAN_C1        8'h1f
`define CHAN_D0        8'h20
`define CHAN_D1        8'h21

`endif

// ==== verilog/downlink_pkg.sv ====
// Types shared by the downlink word framer, its bench and the programmer model.
// Assumes nothing of its surroundings.
package downlink_pkg;
  typedef enum logic [1:0] {SRC_REGULAR, SRC_DISPLAY, SRC_CHANNEL} src_sel_t;
  typedef enum logic [2:0] {LIST_ORBIT, LIST_COAST, LIST_RNDZ, LIST_DESCENT,
                            LIST_SURFACE, LIST_INIT, LIST_DUMP} list_t;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD} frm_st_t;

  typedef struct packed {
    frm_st_t     st;
    logic [6:0]  word;
    list_t       list;
    logic [7:0]  dump_left;
    logic [4:0]  cnt;
    logic [4:0]  ridx;
    logic        pend;
    logic [4:0]  pidx;
    logic        mrd;
    logic [5:0]  maddr;
    logic [14:0] r1;
    logic [14:0] r2;
    logic [15:0] ch34;
    logic [15:0] ch35;
    logic [39:0] wrd;
    logic        wvalid;
    logic        src_rd;
    src_sel_t    src_sel;
    logic [7:0]  src_idx;
    logic [2:0]  ep;
  } frm_state_t;
endpackage

// ==== verilog/snap_if.sv ====
// Port bundle between the framer and its snapshot memory.
// Assumes one clock shared by both ends.
interface snap_if #(parameter int AW = 6, parameter int DW = 15);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic          re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// ==== verilog/snapshot_mem.sv ====
// Two banks of snapshot registers; read data comes out of a register.
// Assumes write and read requests from the same clock domain.
module snapshot_mem #(
  parameter int AW    = 6,
  parameter int DW    = 15,
  parameter int DEPTH = 48
) (
  input wire logic i_clk, // System clock
  snap_if.mem      bus    // Write and read port
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  // Storage has no reset; contents are only read after a capture
  always_ff @(posedge i_clk) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
    if (bus.re) begin
      rdata_q <= mem_q[bus.raddr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule // snapshot_mem

// ==== test/telem_prog_model.sv ====
// Telemetry programmer model: paces words with end pulses, answers source reads.
// Assumes the framer presents a read one cycle before it samples the data.
module telem_prog_model (
  input  wire logic                   i_clk,       // System clock
  input  wire logic                   i_src_rd,    // Read strobe
  input  wire downlink_pkg::src_sel_t i_src_sel,   // Source class
  input  wire logic [7:0]             i_src_idx,   // Source index
  output      logic                   o_end_pulse, // End pulse to framer
  output      logic [14:0]            o_src_data   // Source answer
);
  timeunit 1ns;
  timeprecision 1ps;
  import downlink_pkg::*;
  logic [4:0] gen   = '0;
  logic       ans   = 1'b0;
  logic [9:0] tag_q = '0;
  initial o_end_pulse = 1'b0;
  initial o_src_data = '0;
  // Latch the request; the answer lands one cycle later
  always @(posedge i_clk) begin
    ans <= i_src_rd;
    tag_q <= {i_src_sel, i_src_idx};
  end
  // Idle cycles show the inverse so a late sample never passes by luck
  always @(negedge i_clk) begin
    if (ans) o_src_data <= {tag_q, gen};
    else o_src_data <= ~o_src_data;
  end
  // One word request; bumping gen makes every live read distinct
  task automatic pulse();
    @(negedge i_clk);
    o_end_pulse = 1'b1;
    gen = gen + 5'h01;
    repeat (2) @(negedge i_clk);
    o_end_pulse = 1'b0;
  endtask
endmodule // telem_prog_model

// ==== test/telemetry_downlink_word_framer_tb.sv ====
// Self-checking bench for the downlink framer: nine passes across every list.
// Assumes the partner model answers source reads and raises the end pulses.
module telemetry_downlink_word_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import downlink_pkg::*;
  localparam logic [14:0] DUMP_ID = 15'h7ff9; // Arbitrary dump identifier
  localparam int          PASSES  = 2;
  logic        I_CLK, I_RST_B, I_END_PULSE, O_SRC_RD, O_WORD_VALID;
  logic [14:0] I_LIST_REQ, I_ELAPSED_HIGH, I_ELAPSED_LOW, I_SRC_DATA;
  logic [15:0] O_CH34, O_CH35;
  logic [39:0] O_WORD;
  logic [7:0]  O_SRC_IDX;
  logic [6:0]  O_WORD_NUM;
  src_sel_t    O_SRC_SEL;
  list_t       O_LIST, cur;
  int          mismatches, checked, seed, gen, gen_a, gen_b, left;
  logic [14:0] ids [6] = '{15'h7ffc, 15'h7fff, 15'h7ffd, 15'h7ffb, 15'h7ffa, 15'h7ffe};
  // Last request is no known identifier, so the list in force must stay
  logic [14:0] nreq [9] = '{15'h7ffc, 15'h7ffd, DUMP_ID, 15'h7fff, 15'h7fff, 15'h7ffa, 15'h7ffe, 15'h1234,
                            15'h1234};
  logic [7:0]  chan [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h1e, 8'h1f, 8'h20, 8'h21};

  downlink_framer #(.DUMP_ID(DUMP_ID), .DUMP_PASSES(8'(PASSES))) u_dut (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_END_PULSE(I_END_PULSE), .I_LIST_REQ(I_LIST_REQ),
    .I_ELAPSED_HIGH(I_ELAPSED_HIGH), .I_ELAPSED_LOW(I_ELAPSED_LOW), .I_SRC_DATA(I_SRC_DATA),
    .O_SRC_RD(O_SRC_RD), .O_SRC_SEL(O_SRC_SEL), .O_SRC_IDX(O_SRC_IDX), .O_CH34(O_CH34),
    .O_CH35(O_CH35), .O_WORD(O_WORD), .O_WORD_VALID(O_WORD_VALID), .O_WORD_NUM(O_WORD_NUM),
    .O_LIST(O_LIST));
  telem_prog_model u_prog (.i_clk(I_CLK), .i_src_rd(O_SRC_RD), .i_src_sel(O_SRC_SEL),
    .i_src_idx(O_SRC_IDX), .o_end_pulse(I_END_PULSE), .o_src_data(I_SRC_DATA));

  // 125 MHz system clock
  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end

  // Register with odd parity in the low bit
  function automatic logic [15:0] par(input logic [14:0] d);
    return {d, ~^d};
  endfunction

  // Source register the partner answers with for word w, half k
  // Display and channel words exist only on nominal lists; the dump reads all live
  function automatic logic [14:0] src(input int w, input int k, input int g, input bit nom);
    int sel, idx;
    sel = 0;
    idx = (w - 1) * 2 + k;
    if (nom && w >= 45 && w <= 50) begin
      sel = 1;
      idx = (w - 45) * 2 + k;
    end
    if (nom && w >= 91 && w <= 94) begin
      sel = 2;
      idx = chan[(w - 91) * 2 + k];
    end
    return {sel[1:0], idx[7:0], g[4:0]};
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One word: pick list at pass start, pulse, predict, compare
  task automatic run_word(input int w);
    int          n, g;
    logic [14:0] d1, d2;
    logic [15:0] p1;
    logic        ord;
    logic [31:0] eh, el;
    eh = $random(seed);
    el = $random(seed);
    I_ELAPSED_HIGH = eh[14:0];
    I_ELAPSED_LOW = el[14:0];
    if (w == 1) begin
      if (left > 0) left--;
      else if (I_LIST_REQ == DUMP_ID) begin
        cur = LIST_DUMP;
        left = PASSES - 1;
      end
      else for (int i = 0; i < 6; i++) if (ids[i] == I_LIST_REQ) cur = list_t'(i);
    end
    u_prog.pulse();
    gen++;
    // Snapshot words keep the generation seen at their capture word
    if (cur != LIST_DUMP && w == 2) gen_a = gen;
    if (cur != LIST_DUMP && w == 52) gen_b = gen;
    g = gen;
    if (cur != LIST_DUMP && w >= 2 && w <= 13) g = gen_a;
    if (cur != LIST_DUMP && w >= 52 && w <= 63) g = gen_b;
    d1 = src(w, 0, g, cur != LIST_DUMP);
    d2 = src(w, 1, g, cur != LIST_DUMP);
    ord = 1'b1;
    if (w == 1) begin
      ord = 1'b0;
      d1 = (cur == LIST_DUMP) ? DUMP_ID : ids[cur];
      d2 = 15'h7ee0;
    end
    if (w == 51 && cur != LIST_DUMP) begin
      ord = 1'b0;
      d1 = {1'b0, eh[13:0]};
      d2 = el[14:0];
    end
    p1 = par(d1);
    for (n = 0; n < 40 && O_WORD_VALID !== 1'b1; n++) @(negedge I_CLK);
    if (n == 40) begin
      mismatches++;
      $display("no word strobe at %0t", $time);
    end
    check(40'(O_CH34), 40'(p1));
    check(40'(O_CH35), 40'(par(d2)));
    check(O_WORD, {ord, p1, par(d2), p1[15:9]});
    check(40'(O_WORD_NUM), 40'(w));
    check(40'(O_LIST), 40'(cur));
    repeat (40 - n) @(negedge I_CLK);
  endtask

  // Nine passes: requests change mid-pass, dump ignores them, unknown ids keep the list
  initial begin
    seed = 93196;
    mismatches = 0;
    checked = 0;
    gen = 0;
    gen_a = 0;
    gen_b = 0;
    left = 0;
    cur = LIST_COAST;
    I_RST_B = 1'b0;
    I_LIST_REQ = 15'h7ffb;
    I_ELAPSED_HIGH = '0;
    I_ELAPSED_LOW = '0;
    repeat (5) @(negedge I_CLK);
    check(40'(O_WORD_NUM), 40'(100));
    check(40'(O_LIST), 40'(LIST_COAST));
    I_RST_B = 1'b1;
    for (int p = 0; p < 9; p++) begin
      for (int w = 1; w <= 100; w++) begin
        run_word(w);
        if (w == 50) I_LIST_REQ = nreq[p];
      end
      $display("pass %0d done, list %0d", p, cur);
    end
    end_sim();
  end

  // Hang guard: about 310 us expected, cut at 400 us
  initial begin
    #400000;
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // telemetry_downlink_word_framer_tb
